// *** design/clk_cond_map.vh ***
// register offsets, field positions, reset values and timing counts of the clock conditioning block
// included by the block's single design module and by its port checker
`ifndef CLK_COND_MAP_VH
`define CLK_COND_MAP_VH

// register offsets (byte addresses on the register port)
`define ADDR_DIV_TWO        8'h00
`define ADDR_DIV_THREE      8'h04
`define ADDR_LOCK_WINDOW    8'h08
`define ADDR_LOCK_STATUS    8'h0C
`define ADDR_SPREAD_FREQ    8'h10
`define ADDR_SPREAD_DEPTH   8'h14
`define ADDR_SPREAD_ENABLE  8'h18
`define ADDR_LOW_FREQ_MODE  8'h1C
`define ADDR_FEEDBACK_SEL   8'h20
`define ADDR_RESYNC_REQ     8'h24
`define ADDR_PLL_OUT_DIV    8'h28
`define ADDR_PLL_REF_DIV    8'h2C
`define ADDR_PLL_FB_DIV     8'h30
`define ADDR_RESYNC_ENABLE  8'h34

// field positions
`define LOCK_STATUS_BIT     4
`define SUPPLY_3V3_BIT      2
`define SUPPLY_1V2_BIT      1
`define LOW_FREQ_BIT        0

// reset values
`define RST_DIV_VALUE       8'h00
`define RST_FIELD           8'h00
`define RST_RESYNC_ENABLE   2'h3

// timing counts
`define LOCK_DELAY_BASE_EXP 5
`define PLL_SETTLE_CYCLES   16'h0040

`endif

// *** design/clock_divider_pll_config.v ***
// configuration and status registers of a clock conditioning circuit, with the two
// general-purpose output dividers and a behavioural lock tracker for the PLL.
// assumes: one clock mclk, inputs synchronous to it, pll_locked_raw from the analog PLL.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "clk_cond_map.vh"

// Overview of operation
// RL1: divider two divides by setting, zero and one divide by two
// RL2: divider three divides by setting, zero and one divide by two
// RL3: lock window code selects doubling ppm tolerance
// RL4: status bit four reads PLL lock
// RL5: lock delay equals two to (code+5)
// RL6: five-bit spread modulation frequency setting stored
// RL7: two-bit spread depth code selects percent
// RL8: spread enable ignored when external feedback, 32k
// RL9: 32 kHz mode bit selects low-frequency mode
// RL10: feedback select picks internal or external path
// RL11: software pulses resync request one then zero
// RL12: output divider codes 0-5 give 1..32
// RL13: reference divider divides by field plus one
// RL14: feedback divider uses five bits when spreading
// RL15: divider reset held while request high, if enabled
// RL16: reserved bits read zero, ignore writes
// RL17: software changes settings then requests resync
module clock_divider_pll_config (
	// clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// register port
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [7:0]  rdata,
	// pll status from the analog core
	input  wire        pll_locked_raw,
	// divided clocks
	output reg         clk_div_two,
	output reg         clk_div_three,
	// pll settings to the analog core, and the qualified lock status
	output reg  [2:0]  lock_window,
	output reg  [3:0]  lock_delay_count,
	output reg  [4:0]  spread_mod_frequency,
	output reg  [1:0]  spread_mod_depth,
	output reg         spread_active,
	output reg         low_freq_mode,
	output reg         internal_feedback_select,
	output reg  [5:0]  pll_output_ratio,
	output reg  [6:0]  pll_reference_ratio,
	output reg  [8:0]  pll_feedback_ratio,
	output reg  [16:0] lock_tolerance_ppm,
	output reg  [20:0] lock_delay_cycles,
	output reg  [1:0]  spread_depth_tenths,
	output reg         pll_locked
);

	localparam LK_IDLE   = 2'd0;
	localparam LK_SETTLE = 2'd1;
	localparam LK_LOCKED = 2'd2;

	reg  [7:0]  divider_two_value;
	reg  [7:0]  divider_three_value;
	reg         spread_enable;
	reg  [1:0]  supply_mode;
	reg         resync_request;
	reg  [1:0]  soft_resync_enable;
	reg  [2:0]  pll_output_div;
	reg  [5:0]  pll_reference_div;
	reg  [7:0]  pll_feedback_div;
	reg  [1:0]  lk_state;
	reg  [20:0] lk_count;
	reg  [7:0]  div_count [0:1];
	reg  [1:0]  div_phase;
	reg  [7:0]  next_rdata;
	wire [7:0]  div_value [0:1];
	wire        spread_ok;
	wire [20:0] delay_full;
	wire [4:0]  delay_exp;

	assign div_value[0] = divider_two_value;
	assign div_value[1] = divider_three_value;
	assign spread_ok    = spread_enable & ~(~internal_feedback_select & low_freq_mode); // RL8
	// five-bit sum so code fifteen reaches a shift of twenty
	assign delay_exp    = {1'b0, lock_delay_count} + 5'd`LOCK_DELAY_BASE_EXP;
	assign delay_full   = 21'h000001 << delay_exp; // RL5

	// register writes, one flop group per field; reserved bits are never stored
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			divider_two_value <= `RST_DIV_VALUE;
		end else if (wr && addr == `ADDR_DIV_TWO) begin
			divider_two_value <= wdata;
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			divider_three_value <= `RST_DIV_VALUE;
		end else if (wr && addr == `ADDR_DIV_THREE) begin
			divider_three_value <= wdata;
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lock_window <= 3'h0;
		end else if (wr && addr == `ADDR_LOCK_WINDOW) begin
			lock_window <= wdata[2:0]; // RL16
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lock_delay_count <= 4'h0;
		end else if (wr && addr == `ADDR_LOCK_STATUS) begin
			lock_delay_count <= wdata[3:0];
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			spread_mod_frequency <= 5'h00;
		end else if (wr && addr == `ADDR_SPREAD_FREQ) begin
			spread_mod_frequency <= wdata[4:0]; // RL6
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			spread_mod_depth <= 2'h0;
		end else if (wr && addr == `ADDR_SPREAD_DEPTH) begin
			spread_mod_depth <= wdata[1:0]; // RL7
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			spread_enable <= 1'b0;
		end else if (wr && addr == `ADDR_SPREAD_ENABLE) begin
			spread_enable <= wdata[0];
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			supply_mode <= 2'h0;
		end else if (wr && addr == `ADDR_LOW_FREQ_MODE) begin
			supply_mode <= wdata[`SUPPLY_3V3_BIT:`SUPPLY_1V2_BIT];
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			low_freq_mode <= 1'b0;
		end else if (wr && addr == `ADDR_LOW_FREQ_MODE) begin
			low_freq_mode <= wdata[`LOW_FREQ_BIT]; // RL9
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			internal_feedback_select <= 1'b0;
		end else if (wr && addr == `ADDR_FEEDBACK_SEL) begin
			internal_feedback_select <= wdata[0]; // RL10
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			resync_request <= 1'b0;
		end else if (wr && addr == `ADDR_RESYNC_REQ) begin
			resync_request <= wdata[0]; // RL11
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_output_div <= 3'h0;
		end else if (wr && addr == `ADDR_PLL_OUT_DIV) begin
			pll_output_div <= wdata[2:0];
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_reference_div <= 6'h00;
		end else if (wr && addr == `ADDR_PLL_REF_DIV) begin
			pll_reference_div <= wdata[5:0];
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_feedback_div <= 8'h00;
		end else if (wr && addr == `ADDR_PLL_FB_DIV) begin
			pll_feedback_div <= wdata;
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			soft_resync_enable <= `RST_RESYNC_ENABLE;
		end else if (wr && addr == `ADDR_RESYNC_ENABLE) begin
			soft_resync_enable <= wdata[1:0];
		end
	end

	// read mux; unmapped addresses and reserved bits read zero
	always @* begin
		next_rdata = 8'h00;
		case (addr)
		`ADDR_DIV_TWO:       next_rdata = divider_two_value;
		`ADDR_DIV_THREE:     next_rdata = divider_three_value;
		`ADDR_LOCK_WINDOW:   next_rdata = {5'h00, lock_window};
		`ADDR_LOCK_STATUS:   next_rdata = {3'h0, pll_locked, lock_delay_count}; // RL4
		`ADDR_SPREAD_FREQ:   next_rdata = {3'h0, spread_mod_frequency};
		`ADDR_SPREAD_DEPTH:  next_rdata = {6'h00, spread_mod_depth};
		`ADDR_SPREAD_ENABLE: next_rdata = {7'h00, spread_enable};
		`ADDR_LOW_FREQ_MODE: next_rdata = {5'h00, supply_mode, low_freq_mode};
		`ADDR_FEEDBACK_SEL:  next_rdata = {7'h00, internal_feedback_select};
		`ADDR_RESYNC_REQ:    next_rdata = {7'h00, resync_request};
		`ADDR_PLL_OUT_DIV:   next_rdata = {5'h00, pll_output_div};
		`ADDR_PLL_REF_DIV:   next_rdata = {2'h0, pll_reference_div};
		`ADDR_PLL_FB_DIV:    next_rdata = pll_feedback_div;
		`ADDR_RESYNC_ENABLE: next_rdata = {6'h00, soft_resync_enable};
		default:             next_rdata = 8'h00; // RL16
		endcase
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

	// decoded pll settings
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lock_tolerance_ppm <= 17'h001F4;
		end else begin
			lock_tolerance_ppm <= 17'h001F4 << lock_window; // RL3
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lock_delay_cycles <= 21'h000020;
		end else begin
			lock_delay_cycles <= delay_full; // RL5
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			spread_depth_tenths <= 2'h0;
		end else begin
			spread_depth_tenths <= spread_ok ? spread_mod_depth : 2'h0; // RL7
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			spread_active <= 1'b0;
		end else begin
			spread_active <= spread_ok; // RL8
		end
	end

	// invalid codes 110/111 clamp to the largest ratio
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_output_ratio <= 6'h01;
		end else begin
			pll_output_ratio <= (pll_output_div > 3'h5) ? 6'h20
			                    : (6'h01 << pll_output_div); // RL12
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_reference_ratio <= 7'h01;
		end else begin
			pll_reference_ratio <= {1'b0, pll_reference_div} + 7'h01; // RL13
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pll_feedback_ratio <= 9'h001;
		end else begin
			pll_feedback_ratio <= spread_ok ? {4'h0, pll_feedback_div[4:0]} + 9'h001
			                      : {1'b0, pll_feedback_div} + 9'h001; // RL14
		end
	end

	// lock indication qualified by the lock delay count
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lk_state   <= LK_IDLE;
			lk_count   <= 21'h000000;
			pll_locked <= 1'b0;
		end else begin
			case (lk_state)
			LK_IDLE: begin
				pll_locked <= 1'b0;
				lk_count   <= 21'h000000;
				if (pll_locked_raw)
					lk_state <= LK_SETTLE;
			end
			LK_SETTLE: begin
				if (!pll_locked_raw) begin
					lk_state <= LK_IDLE;
				end else if (lk_count >= delay_full - 21'h000001) begin
					lk_state   <= LK_LOCKED;
					pll_locked <= 1'b1; // RL4
				end else begin
					lk_count <= lk_count + 21'h000001; // RL5
				end
			end
			LK_LOCKED: begin
				if (!pll_locked_raw) begin
					lk_state   <= LK_IDLE;
					pll_locked <= 1'b0;
				end
			end
			default: lk_state <= LK_IDLE;
			endcase
		end
	end

	// output dividers two and three share one structure
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_div
			reg sync_rst;
			// registered so the reset is set and released on a clock edge
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					sync_rst <= 1'b0;
				end else begin
					sync_rst <= soft_resync_enable[g] & resync_request; // RL15
				end
			end
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					div_count[g] <= 8'h00;
					div_phase[g] <= 1'b0;
				end else if (sync_rst) begin // RL11
					div_count[g] <= 8'h00;
					div_phase[g] <= 1'b0;
				end else if (div_value[g] <= 8'h01) begin
					div_count[g] <= 8'h00;
					div_phase[g] <= ~div_phase[g];
				end else if (div_count[g] >= div_value[g] - 8'h01) begin
					div_count[g] <= 8'h00;
					div_phase[g] <= 1'b0;
				end else begin
					div_count[g] <= div_count[g] + 8'h01;
					div_phase[g] <= (div_count[g] + 8'h01) >= (div_value[g] >> 1);
				end
			end
		end
	endgenerate

	// divided clocks leave through flip-flops; 0 and 1 toggle every mclk cycle, half the mclk rate
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clk_div_two <= 1'b0;
		end else begin
			clk_div_two <= div_phase[0]; // RL1
		end
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clk_div_three <= 1'b0;
		end else begin
			clk_div_three <= div_phase[1]; // RL2
		end
	end

endmodule // clock_divider_pll_config

// *** dv/cdpc_properties.sv ***
// port checks of the clock conditioning block
// assumes: bound into clock_divider_pll_config, one clock
`timescale 1ns/100ps
`include "clk_cond_map.vh"
module cdpc_props (
	// clock, reset, bus, raw pll lock
	input logic        mclk, nrst, rd, pll_locked_raw,
	input logic [7:0]  addr, rdata,
	// status and settings
	input logic        spread_active, low_freq_mode, internal_feedback_select, pll_locked,
	input logic [1:0]  spread_mod_depth, spread_depth_tenths,
	input logic [2:0]  lock_window,
	input logic [3:0]  lock_delay_count,
	input logic [8:0]  pll_feedback_ratio,
	input logic [16:0] lock_tolerance_ppm,
	input logic [20:0] lock_delay_cycles
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata set");
	property p_lk; $past(rd) && $past(addr) == `ADDR_LOCK_STATUS |-> rdata[7:4] == {3'h0, $past(pll_locked)}; endproperty
	a_lk: assert property (p_lk) else $error("lock bit");
	property p_tol; $stable(lock_window) |-> lock_tolerance_ppm == (17'h01F4 << lock_window); endproperty
	a_tol: assert property (p_tol) else $error("tolerance");
	property p_dly; $stable(lock_delay_count) |-> lock_delay_cycles == 21'h1 << (lock_delay_count + 5); endproperty
	a_dly: assert property (p_dly) else $error("delay");
	property p_sse; $stable({internal_feedback_select, low_freq_mode}) && spread_active |-> internal_feedback_select || !low_freq_mode; endproperty
	a_sse: assert property (p_sse) else $error("spread");
	property p_dep; $stable(spread_active) && $stable(spread_mod_depth) |-> spread_depth_tenths == (spread_active ? spread_mod_depth : 2'h0); endproperty
	a_dep: assert property (p_dep) else $error("depth");
	property p_fb; spread_active && $stable(spread_active) |-> pll_feedback_ratio <= 9'h020; endproperty
	a_fb: assert property (p_fb) else $error("fb ratio");
	property p_drop; $fell(pll_locked_raw) |=> !pll_locked; endproperty
	a_drop: assert property (p_drop) else $error("unlock");
	property p_rise; $rose(pll_locked) |-> $past(pll_locked_raw, 30); endproperty
	a_rise: assert property (p_rise) else $error("early lock");
endmodule // cdpc_props
bind clock_divider_pll_config cdpc_props props_i (.mclk(mclk), .nrst(nrst), .rd(rd),
	.pll_locked_raw(pll_locked_raw), .addr(addr), .rdata(rdata), .spread_active(spread_active),
	.low_freq_mode(low_freq_mode), .internal_feedback_select(internal_feedback_select),
	.pll_locked(pll_locked), .spread_mod_depth(spread_mod_depth), .lock_window(lock_window),
	.spread_depth_tenths(spread_depth_tenths), .lock_delay_count(lock_delay_count),
	.pll_feedback_ratio(pll_feedback_ratio), .lock_tolerance_ppm(lock_tolerance_ppm),
	.lock_delay_cycles(lock_delay_cycles));

// *** dv/tb_top.sv ***
// self-checking bench of the clock conditioning block
// assumes: design and checker compiled first
`timescale 1ns/100ps
module tb_top;
	logic        mclk = 0, nrst = 0, wr = 0, rd = 0, pll_locked_raw = 0, e;
	logic [7:0]  addr = 0, wdata = 0, seed = 8'h53, d;
	wire  [7:0]  rdata;
	wire         clk_div_two, clk_div_three, spread_active, low_freq_mode, ifs, pll_locked;
	wire  [1:0]  smd, tenths;
	wire  [2:0]  lock_window;
	wire  [3:0]  ldc;
	wire  [4:0]  smf;
	wire  [5:0]  out_r;
	wire  [6:0]  ref_r;
	wire  [8:0]  fb_r;
	wire  [16:0] tol;
	wire  [20:0] dly;
	int          fails = 0, n_tests = 0, cyc = 0, i, c;
	clock_divider_pll_config clock_divider_pll_config_i (.mclk(mclk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pll_locked_raw(pll_locked_raw), .clk_div_two(clk_div_two),
		.clk_div_three(clk_div_three), .lock_window(lock_window), .lock_delay_count(ldc),
		.spread_mod_frequency(smf), .spread_mod_depth(smd), .spread_active(spread_active),
		.low_freq_mode(low_freq_mode), .internal_feedback_select(ifs),
		.pll_output_ratio(out_r), .pll_reference_ratio(ref_r), .pll_feedback_ratio(fb_r),
		.lock_tolerance_ppm(tol), .lock_delay_cycles(dly), .spread_depth_tenths(tenths),
		.pll_locked(pll_locked));
	always #25 mclk = ~mclk;
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function logic [7:0] mask(input logic [7:0] a);
		case (a)
			8'h00, 8'h04, 8'h30: return 8'hFF;
			8'h08, 8'h1C, 8'h28: return 8'h07;
			8'h0C: return 8'h0F;
			8'h10: return 8'h1F;
			8'h14, 8'h34: return 8'h03;
			8'h18, 8'h20, 8'h24: return 8'h01;
			8'h2C: return 8'h3F;
			default: return 8'h00;
		endcase
	endfunction
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize;
		end
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (x !== g) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", n, x, g);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [7:0] x);
		@(posedge mclk);
		addr <= a;
		wdata <= x;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
	endtask
	task rreg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		@(negedge mclk);
		d = rdata;
	endtask
	task settle;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
	task period(input logic s, input logic [7:0] n);
		int k, r, t;
		logic p, q;
		wreg(s ? 8'h04 : 8'h00, n);
		repeat (2 * n + 4) @(posedge mclk);
		r = 0;
		t = 0;
		p = 1;
		for (k = 0; k < 1200 && r < 3; k++) begin
			@(negedge mclk);
			q = s ? clk_div_three : clk_div_two;
			if (q === 1 && p === 0) begin
				r++;
				t = (r == 3) ? k - t : k;
			end
			p = q;
		end
		chk("period", (n < 2) ? 2 : n, t);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		nrst <= 1;
		for (i = 0; i < 15; i++) begin
			rreg(8'(i * 4));
			chk("reset", (i == 13) ? 3 : 0, d);
			seed = lfsr(seed);
			wreg(8'(i * 4), seed);
			rreg(8'(i * 4));
			chk("rw", seed & mask(8'(i * 4)), d);
		end
		wreg(8'h24, 0);
		wreg(8'h34, 3);
		$display("registers done");
		for (c = 0; c < 16; c++) begin
			seed = lfsr(seed);
			wreg(8'h08, 8'(c));
			wreg(8'h28, 8'(c));
			wreg(8'h0C, 8'(c));
			wreg(8'h2C, seed);
			wreg(8'h10, seed);
			settle;
			chk("tol", 500 << c[2:0], tol);
			chk("lock_window", c[2:0], lock_window);
			chk("lock_delay_count", c[3:0], ldc);
			chk("outdiv", (c[2:0] > 5) ? 32 : 1 << c[2:0], out_r);
			chk("delay", 1 << (c + 5), dly);
			chk("refdiv", seed[5:0] + 1, ref_r);
			chk("ssfreq", seed[4:0], smf);
		end
		for (c = 0; c < 8; c++) begin
			seed = (c == 0) ? 8'hFF : lfsr(seed);
			wreg(8'h20, c[2]);
			wreg(8'h1C, c[1]);
			wreg(8'h18, c[0]);
			wreg(8'h14, seed);
			wreg(8'h30, seed);
			settle;
			e = c[0] && !(!c[2] && c[1]);
			chk("spread", e, spread_active);
			chk("depth", e ? seed[1:0] : 0, tenths);
			chk("ssdepth", seed[1:0], smd);
			chk("fbdiv", e ? seed[4:0] + 1 : seed + 1, fb_r);
			chk("low_freq_mode", c[1], low_freq_mode);
			chk("fse", c[2], ifs);
		end
		$display("fields done");
		for (i = 0; i < 12; i++) period(i % 2, (i < 10) ? 8'(i / 2) : 8'hFF);
		$display("dividers done");
		wreg(8'h00, 8'h05);
		wreg(8'h04, 8'h05);
		wreg(8'h24, 8'h01);
		settle;
		for (i = 0; i < 6; i++) @(negedge mclk) chk("held", 0, {clk_div_two, clk_div_three});
		wreg(8'h24, 8'h00);
		for (i = 0; i < 12; i++) @(negedge mclk) chk("align", clk_div_two, clk_div_three);
		wreg(8'h0C, 8'h00);
		pll_locked_raw <= 1;
		repeat (30) @(posedge mclk);
		@(negedge mclk) chk("early", 0, pll_locked);
		for (i = 0; i < 10 && pll_locked !== 1; i++) @(negedge mclk);
		chk("lock", 1, pll_locked);
		rreg(8'h0C);
		chk("lockbit", 8'h10, d);
		@(posedge mclk) pll_locked_raw <= 0;
		settle;
		chk("unlock", 0, pll_locked);
		$display("lock done");
		summarize;
	end
endmodule // tb_top
